// file: design/usbf_map.vh
/*
 * Register offsets, field positions, reset values and timing counts for the
 * serial port status, divisor and FIFO interrupt block.
 * Assumes an 8-bit register port with byte addresses and one system clock.
 */
`ifndef USBF_MAP_VH
`define USBF_MAP_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define USBF_ADDR_DATA 8'h80
`define USBF_ADDR_IER 8'h82
`define USBF_ADDR_IIR_FCR 8'h84
`define USBF_ADDR_LCR 8'h86
`define USBF_ADDR_MCR 8'h88
`define USBF_ADDR_LSR 8'h8a
`define USBF_ADDR_MSR 8'h8c
`define USBF_ADDR_SCR 8'h8e
`define USBF_ADDR_DIV_LO 8'h90
`define USBF_ADDR_DIV_HI 8'h92

// ----------------------------------------
// field positions
// ----------------------------------------
`define USBF_MCR_LOOP 4
`define USBF_FCR_EN 0
`define USBF_FCR_RX_CLR 1
`define USBF_FCR_TX_CLR 2
`define USBF_LCR_STOP2 2
`define USBF_LCR_PAR_EN 3
`define USBF_LCR_PAR_EVEN 4

// ----------------------------------------
// reset values and identification codes
// ----------------------------------------
`define USBF_LCR_RESET 8'h03
`define USBF_DIV_RESET 16'h0002
`define USBF_IIR_NONE 4'h1
`define USBF_IIR_LINE 4'h6
`define USBF_IIR_RXDATA 4'h4
`define USBF_IIR_TIMEOUT 4'hc
`define USBF_IIR_TX_HOLDING_EMPTY 4'h2
`define USBF_IIR_MODEM 4'h0

// ----------------------------------------
// timing counts
// ----------------------------------------
`define USBF_OVERSAMPLE 10'h010
`define USBF_TO_CHARS 10'h004
`define USBF_SAMPLE_MID 4'h7
`define USBF_SAMPLE_LAST 4'hf
`define USBF_FIFO_DEPTH 5'h10

`endif

// file: design/usbf_uart.v
/*
 * Serial port core: modem status with change detection, scratch byte,
 * baud divisor, 16-deep receive and transmit FIFOs with their interrupt,
 * timeout and polled behaviour, and the line framing behind them.
 * Assumes all inputs synchronous to mclk and a register master that never
 * issues read and write strobes together.
 */
`timescale 1ns/1ps
`include "usbf_map.vh"

module usbf_uart (
    input wire mclk,
    input wire reset_n,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire serial_in,
    output wire serial_out,
    input wire carrier_detect_pin_n,
    input wire ring_pin_n,
    input wire set_ready_pin_n,
    input wire clear_to_send_pin_n,
    output wire term_ready_n,
    output wire req_send_n,
    output wire aux_output_one_n,
    output wire aux_output_two_n,
    output wire irq
);

localparam RX_IDLE = 3'b001;
localparam RX_START = 3'b010;
localparam RX_BITS = 3'b100;

// ----------------------------------------
// helpers
// ----------------------------------------
function [3:0] usbf_data_bits;
    input [1:0] wl;
    begin
        usbf_data_bits = {2'b00, wl} + 4'h5;
    end
endfunction

function [3:0] usbf_frame_bits;
    input [7:0] lcr;
    begin
        usbf_frame_bits = 4'h1 + usbf_data_bits(lcr[1:0]) + {3'b000, lcr[`USBF_LCR_PAR_EN]} +
                          (lcr[`USBF_LCR_STOP2] ? 4'h2 : 4'h1);
    end
endfunction

function [4:0] usbf_trig;
    input [1:0] sel;
    begin
        case (sel)
            2'h0: usbf_trig = 5'h01;
            2'h1: usbf_trig = 5'h04;
            2'h2: usbf_trig = 5'h08;
            default: usbf_trig = 5'h0e;
        endcase
    end
endfunction

// ----------------------------------------
// register state
// ----------------------------------------
reg [3:0] ier_reg;
reg [7:0] lcr_reg;
reg [4:0] mcr_reg;
reg fcr_en_reg;
reg [1:0] trig_sel_reg;
reg [7:0] scratch_byte_reg;
reg [15:0] div_reg;
reg [15:0] baud_cnt_reg;
reg tick_reg;
reg [3:0] msr_prev_reg;
reg [3:0] msr_delta_reg;
reg oe_reg;
reg [3:0] iir_id;

wire loop = mcr_reg[`USBF_MCR_LOOP];
wire [3:0] frame_bits = usbf_frame_bits(lcr_reg);
wire [3:0] nbits = usbf_data_bits(lcr_reg[1:0]);
wire [4:0] limit = fcr_en_reg ? `USBF_FIFO_DEPTH : 5'h01;

wire wr_data = reg_wr && (reg_addr == `USBF_ADDR_DATA);
wire wr_fcr = reg_wr && (reg_addr == `USBF_ADDR_IIR_FCR);
wire wr_lo = reg_wr && (reg_addr == `USBF_ADDR_DIV_LO);
wire wr_hi = reg_wr && (reg_addr == `USBF_ADDR_DIV_HI);
wire rd_data = reg_rd && (reg_addr == `USBF_ADDR_DATA);
wire rd_iir = reg_rd && (reg_addr == `USBF_ADDR_IIR_FCR);
wire rd_lsr = reg_rd && (reg_addr == `USBF_ADDR_LSR);
wire rd_msr = reg_rd && (reg_addr == `USBF_ADDR_MSR);
wire fcr_toggle = wr_fcr && (reg_wdata[`USBF_FCR_EN] != fcr_en_reg);
wire rx_flush = wr_fcr && (reg_wdata[`USBF_FCR_RX_CLR] || fcr_toggle);
wire tx_flush = wr_fcr && (reg_wdata[`USBF_FCR_TX_CLR] || fcr_toggle);
wire [15:0] div_next = wr_lo ? {div_reg[15:8], reg_wdata} : {reg_wdata, div_reg[7:0]};

// ----------------------------------------
// modem status
// ----------------------------------------
// bit order dcd, ri, dsr, cts; loopback swaps in the control outputs
wire [3:0] msr_cur = loop ? {mcr_reg[3], mcr_reg[2], mcr_reg[0], mcr_reg[1]} :
                     ~{carrier_detect_pin_n, ring_pin_n, set_ready_pin_n, clear_to_send_pin_n};
wire [3:0] msr_event = {msr_cur[3] ^ msr_prev_reg[3],
                        msr_prev_reg[2] & ~msr_cur[2],
                        msr_cur[1:0] ^ msr_prev_reg[1:0]};
// an event in the reading cycle lands after the clear
wire [3:0] msr_delta_next = (rd_msr ? 4'h0 : msr_delta_reg) | msr_event;

// ----------------------------------------
// control registers and baud generator
// ----------------------------------------
always @(posedge mclk) begin
    if (!reset_n) begin
        ier_reg <= 4'h0;
        lcr_reg <= `USBF_LCR_RESET;
        mcr_reg <= 5'h00;
        fcr_en_reg <= 1'b0;
        trig_sel_reg <= 2'h0;
        scratch_byte_reg <= 8'h00;
        div_reg <= `USBF_DIV_RESET;
        baud_cnt_reg <= `USBF_DIV_RESET;
        tick_reg <= 1'b0;
        msr_prev_reg <= 4'h0;
        msr_delta_reg <= 4'h0;
    end else begin
        if (reg_wr && reg_addr == `USBF_ADDR_IER) begin
            ier_reg <= reg_wdata[3:0];
        end
        if (reg_wr && reg_addr == `USBF_ADDR_LCR) begin
            lcr_reg <= reg_wdata;
        end
        if (reg_wr && reg_addr == `USBF_ADDR_MCR) begin
            mcr_reg <= reg_wdata[4:0];
        end
        if (wr_fcr) begin
            fcr_en_reg <= reg_wdata[`USBF_FCR_EN];
            trig_sel_reg <= reg_wdata[7:6];
        end
        if (reg_wr && reg_addr == `USBF_ADDR_SCR) begin
            scratch_byte_reg <= reg_wdata;
        end
        if (wr_lo || wr_hi) begin
            div_reg <= div_next;
            baud_cnt_reg <= div_next;
            tick_reg <= 1'b0;
        end else if (baud_cnt_reg <= 16'h0001) begin
            baud_cnt_reg <= div_reg;
            tick_reg <= 1'b1;
        end else begin
            baud_cnt_reg <= baud_cnt_reg - 16'h0001;
            tick_reg <= 1'b0;
        end
        msr_prev_reg <= msr_cur;
        msr_delta_reg <= msr_delta_next;
    end
end

// ----------------------------------------
// transmit FIFO and shifter
// ----------------------------------------
reg [7:0] tx_mem [0:15];
reg [3:0] tx_wp_reg;
reg [3:0] tx_rp_reg;
reg [4:0] tx_count_reg;
reg [11:0] tx_shift_reg;
reg [3:0] tx_left_reg;
reg [3:0] tx_sub_reg;
reg tx_busy_reg;
reg tx_holding_empty_reg;
reg tx_holding_empty_pend_reg;
reg multi_reg;
reg [9:0] tx_holding_empty_dly_reg;

wire tx_push = wr_data && (tx_count_reg < limit);
wire tx_pop = !tx_busy_reg && (tx_count_reg != 5'h00);
wire tx_line = tx_busy_reg ? tx_shift_reg[0] : 1'b1;
wire [7:0] tx_byte = tx_mem[tx_rp_reg];
wire [7:0] tx_masked = tx_byte & ~(8'hff << nbits);
wire tx_par = ^tx_masked ^ ~lcr_reg[`USBF_LCR_PAR_EVEN];
wire tx_holding_empty_set = !tx_holding_empty_reg && (tx_count_reg == 5'h00) && !tx_push && (tx_holding_empty_dly_reg == 10'h000);

always @(posedge mclk) begin
    if (wr_data && (tx_count_reg < limit)) begin
        tx_mem[tx_wp_reg] <= reg_wdata;
    end
end

always @(posedge mclk) begin
    if (!reset_n || tx_flush) begin
        tx_wp_reg <= 4'h0;
        tx_rp_reg <= 4'h0;
        tx_count_reg <= 5'h00;
        tx_busy_reg <= 1'b0;
        tx_shift_reg <= 12'hfff;
        tx_left_reg <= 4'h0;
        tx_sub_reg <= 4'h0;
        tx_holding_empty_reg <= 1'b1;
        multi_reg <= 1'b0;
        tx_holding_empty_dly_reg <= 10'h000;
        tx_holding_empty_pend_reg <= !reset_n ? 1'b0 : fcr_toggle;
    end else begin
        if (tx_push) begin
            tx_wp_reg <= tx_wp_reg + 4'h1;
        end
        tx_count_reg <= tx_count_reg + {4'h0, tx_push} - {4'h0, tx_pop};
        if (tx_count_reg >= 5'h02) begin
            multi_reg <= 1'b1;
        end else if (tx_holding_empty_set) begin
            multi_reg <= 1'b0;
        end
        if (tx_pop) begin
            tx_rp_reg <= tx_rp_reg + 4'h1;
            tx_busy_reg <= 1'b1;
            tx_left_reg <= frame_bits;
            tx_sub_reg <= 4'h0;
            tx_shift_reg <= (12'hffe << nbits) ^ ({11'h000, lcr_reg[`USBF_LCR_PAR_EN] & ~tx_par} << (nbits + 4'h1)) |
                            {3'b000, tx_masked, 1'b0};
            // lone byte: hold empty until one character minus its final stop bit
            if (fcr_en_reg && tx_count_reg == 5'h01 && !tx_push && !multi_reg) begin
                tx_holding_empty_dly_reg <= {6'h00, frame_bits - 4'h1} * `USBF_OVERSAMPLE;
            end
        end else if (tx_busy_reg && tick_reg) begin
            tx_sub_reg <= tx_sub_reg + 4'h1;
            if (tx_sub_reg == `USBF_SAMPLE_LAST) begin
                tx_shift_reg <= {1'b1, tx_shift_reg[11:1]};
                tx_left_reg <= tx_left_reg - 4'h1;
                tx_busy_reg <= (tx_left_reg != 4'h1);
            end
        end
        if (tx_holding_empty_dly_reg != 10'h000 && tick_reg && !tx_pop) begin
            tx_holding_empty_dly_reg <= tx_holding_empty_dly_reg - 10'h001;
        end
        if (tx_push) begin
            tx_holding_empty_reg <= 1'b0;
        end else if (tx_holding_empty_set) begin
            tx_holding_empty_reg <= 1'b1;
        end
        // a new empty event wins over a clear in the same cycle
        if (tx_holding_empty_set) begin
            tx_holding_empty_pend_reg <= 1'b1;
        end else if (wr_data || (rd_iir && iir_id == `USBF_IIR_TX_HOLDING_EMPTY)) begin
            tx_holding_empty_pend_reg <= 1'b0;
        end
    end
end

assign serial_out = loop ? 1'b1 : tx_line;

// ----------------------------------------
// receiver
// ----------------------------------------
reg [2:0] rx_state_reg;
reg [3:0] rx_sub_reg;
reg [3:0] rx_idx_reg;
reg [11:0] rx_frame_reg;
reg rx_push_reg;
reg [10:0] rx_word_reg;
reg [10:0] rx_mem [0:15];
reg [3:0] rx_wp_reg;
reg [3:0] rx_rp_reg;
reg [4:0] rx_count_reg;
reg [4:0] rx_err_cnt_reg;
reg [9:0] to_cnt_reg;
reg to_flag_reg;

wire rx_line = loop ? tx_line : serial_in;
wire [3:0] rx_stop_idx = nbits + {3'b000, lcr_reg[`USBF_LCR_PAR_EN]};
wire [11:0] rx_full = rx_frame_reg | ({11'h000, rx_line} << rx_stop_idx);
wire [7:0] rx_data = rx_full[7:0] & ~(8'hff << nbits);
wire rx_perr = lcr_reg[`USBF_LCR_PAR_EN] && (^rx_data ^ rx_full[nbits] ^ ~lcr_reg[`USBF_LCR_PAR_EVEN]);
wire rx_brk = (rx_full == 12'h000);
wire rx_pop = rd_data && (rx_count_reg != 5'h00);
wire rx_store = rx_push_reg && (rx_count_reg < limit);
wire [10:0] rx_top = rx_mem[rx_rp_reg];
wire top_err = (rx_count_reg != 5'h00) && (rx_top[10:8] != 3'b000);
wire [9:0] to_limit = {6'h00, frame_bits} * `USBF_OVERSAMPLE * `USBF_TO_CHARS;

always @(posedge mclk) begin
    if (!reset_n) begin
        rx_state_reg <= RX_IDLE;
        rx_sub_reg <= 4'h0;
        rx_idx_reg <= 4'h0;
        rx_frame_reg <= 12'h000;
        rx_push_reg <= 1'b0;
        rx_word_reg <= 11'h000;
    end else begin
        rx_push_reg <= 1'b0;
        case (rx_state_reg)
            RX_IDLE: begin
                rx_sub_reg <= 4'h0;
                if (!rx_line) begin
                    rx_state_reg <= RX_START;
                end
            end
            RX_START: begin
                if (tick_reg) begin
                    rx_sub_reg <= rx_sub_reg + 4'h1;
                    if (rx_sub_reg == `USBF_SAMPLE_MID) begin
                        rx_state_reg <= rx_line ? RX_IDLE : RX_BITS;
                        rx_sub_reg <= 4'h0;
                        rx_idx_reg <= 4'h0;
                        rx_frame_reg <= 12'h000;
                    end
                end
            end
            RX_BITS: begin
                if (tick_reg) begin
                    rx_sub_reg <= rx_sub_reg + 4'h1;
                    if (rx_sub_reg == `USBF_SAMPLE_LAST) begin
                        rx_frame_reg <= rx_frame_reg | ({11'h000, rx_line} << rx_idx_reg);
                        rx_idx_reg <= rx_idx_reg + 4'h1;
                        if (rx_idx_reg == rx_stop_idx) begin
                            rx_state_reg <= RX_IDLE;
                            rx_push_reg <= 1'b1;
                            rx_word_reg <= {rx_brk, !rx_line, rx_perr, rx_data};
                        end
                    end
                end
            end
            default: rx_state_reg <= RX_IDLE;
        endcase
    end
end

always @(posedge mclk) begin
    if (rx_store) begin
        rx_mem[rx_wp_reg] <= rx_word_reg;
    end
end

always @(posedge mclk) begin
    if (!reset_n || rx_flush) begin
        rx_wp_reg <= 4'h0;
        rx_rp_reg <= 4'h0;
        rx_count_reg <= 5'h00;
        rx_err_cnt_reg <= 5'h00;
        to_cnt_reg <= 10'h000;
        to_flag_reg <= 1'b0;
    end else begin
        if (rx_store) begin
            rx_wp_reg <= rx_wp_reg + 4'h1;
        end
        if (rx_pop) begin
            rx_rp_reg <= rx_rp_reg + 4'h1;
        end
        rx_count_reg <= rx_count_reg + {4'h0, rx_store} - {4'h0, rx_pop};
        rx_err_cnt_reg <= rx_err_cnt_reg + {4'h0, rx_store && rx_word_reg[10:8] != 3'b000} -
                          {4'h0, rx_pop && top_err};
        // the read that clears a pending timeout also restarts its timer
        if (rx_pop || rx_push_reg || rx_count_reg == 5'h00) begin
            to_cnt_reg <= 10'h000;
        end else if (tick_reg && to_cnt_reg < to_limit) begin
            to_cnt_reg <= to_cnt_reg + 10'h001;
        end
        if (rx_pop || !fcr_en_reg) begin
            to_flag_reg <= 1'b0;
        end else if (to_cnt_reg >= to_limit && rx_count_reg != 5'h00) begin
            to_flag_reg <= 1'b1;
        end
    end
end

always @(posedge mclk) begin
    if (!reset_n) begin
        oe_reg <= 1'b0;
    end else if (rx_push_reg && rx_count_reg >= limit && !rx_pop) begin
        oe_reg <= 1'b1;
    end else if (rd_lsr) begin
        oe_reg <= 1'b0;
    end
end

// ----------------------------------------
// interrupt identification
// ----------------------------------------
// disabled enables leave each direction polled; no trigger or timeout shows then
wire line_irq = ier_reg[2] && (oe_reg || top_err);
wire rxd_irq = ier_reg[0] && (fcr_en_reg ? rx_count_reg >= usbf_trig(trig_sel_reg) :
                                          rx_count_reg != 5'h00);
wire to_irq = ier_reg[0] && to_flag_reg;
wire thr_irq = ier_reg[1] && tx_holding_empty_pend_reg;
wire ms_irq = ier_reg[3] && (msr_delta_reg != 4'h0);

always @* begin
    if (line_irq) begin
        iir_id = `USBF_IIR_LINE;
    end else if (rxd_irq) begin
        iir_id = `USBF_IIR_RXDATA;
    end else if (to_irq) begin
        iir_id = `USBF_IIR_TIMEOUT;
    end else if (thr_irq) begin
        iir_id = `USBF_IIR_TX_HOLDING_EMPTY;
    end else if (ms_irq) begin
        iir_id = `USBF_IIR_MODEM;
    end else begin
        iir_id = `USBF_IIR_NONE;
    end
end

assign irq = (iir_id != `USBF_IIR_NONE);

// ----------------------------------------
// readback and modem outputs
// ----------------------------------------
wire temt = (tx_count_reg == 5'h00) && !tx_busy_reg;
wire [7:0] lsr_val = {rx_err_cnt_reg != 5'h00, temt, tx_holding_empty_reg,
                      rx_count_reg != 5'h00 ? rx_top[10:8] : 3'b000, oe_reg,
                      rx_count_reg != 5'h00};
reg [7:0] rdata_next;

always @* begin
    case (reg_addr)
        `USBF_ADDR_DATA: rdata_next = rx_top[7:0];
        `USBF_ADDR_IER: rdata_next = {4'h0, ier_reg};
        `USBF_ADDR_IIR_FCR: rdata_next = {fcr_en_reg, fcr_en_reg, 2'b00, iir_id};
        `USBF_ADDR_LCR: rdata_next = lcr_reg;
        `USBF_ADDR_MCR: rdata_next = {3'b000, mcr_reg};
        `USBF_ADDR_LSR: rdata_next = lsr_val;
        `USBF_ADDR_MSR: rdata_next = {msr_cur, msr_delta_reg};
        `USBF_ADDR_SCR: rdata_next = scratch_byte_reg;
        `USBF_ADDR_DIV_LO: rdata_next = div_reg[7:0];
        `USBF_ADDR_DIV_HI: rdata_next = div_reg[15:8];
        default: rdata_next = 8'h00;
    endcase
end

always @(posedge mclk) begin
    if (!reset_n) begin
        reg_rdata <= 8'h00;
    end else if (reg_rd) begin
        reg_rdata <= rdata_next;
    end else begin
        reg_rdata <= 8'h00;
    end
end

// outputs forced inactive in loopback
assign term_ready_n = loop | ~mcr_reg[0];
assign req_send_n = loop | ~mcr_reg[1];
assign aux_output_one_n = loop | ~mcr_reg[2];
assign aux_output_two_n = loop | ~mcr_reg[3];

endmodule

// file: tb/usbf_uart_chk.sv
/*
 * Assertions on the serial port block: modem status bits, scratch byte, loopback pins.
 * Bound to usbf_uart; sees only its ports and keeps its own copy of control writes.
 */
`timescale 1ns/1ps
`include "usbf_map.vh"
module usbf_chk (
    input wire mclk,
    input wire reset_n,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire serial_out,
    input wire carrier_detect_pin_n,
    input wire ring_pin_n,
    input wire set_ready_pin_n,
    input wire clear_to_send_pin_n,
    input wire term_ready_n,
    input wire req_send_n,
    input wire aux_output_one_n,
    input wire aux_output_two_n,
    input wire irq
);
    wire [3:0] pins = {carrier_detect_pin_n, ring_pin_n, set_ready_pin_n, clear_to_send_pin_n};
    wire msr_rd = reg_rd && reg_addr == `USBF_ADDR_MSR;
    wire loop;
    wire quiet;
    reg [7:0] mcr_q;
    reg [7:0] scr_q;
    reg [3:0] ier_q;
    reg [3:0] p1;
    reg [3:0] p2;
    reg pend;

    assign loop = mcr_q[`USBF_MCR_LOOP];
    // ring left out: only its rising pin edge counts
    assign quiet = (((pins ^ p1) | (p1 ^ p2)) & 4'hb) == 4'h0;

    // ----------------------------------------
    // copies of control writes
    // ----------------------------------------
    always @(posedge mclk) begin
        p1 <= pins;
        p2 <= p1;
        if (!reset_n) begin
            mcr_q <= 8'h00;
            scr_q <= 8'h00;
            ier_q <= 4'h0;
            pend <= 1'b0;
        end else begin
            // a read drops the claim, so a change landing with it is not judged
            pend <= (pend || (!loop && ((p1 ^ p2) & 4'hb) != 4'h0)) && !msr_rd;
            if (reg_wr && reg_addr == `USBF_ADDR_MCR)
                mcr_q <= reg_wdata;
            if (reg_wr && reg_addr == `USBF_ADDR_SCR)
                scr_q <= reg_wdata;
            if (reg_wr && reg_addr == `USBF_ADDR_IER)
                ier_q <= reg_wdata[3:0];
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    property p_change_seen;
        msr_rd && pend |=> (reg_rdata & 8'h0b) != 8'h00;
    endproperty
    a_change_seen: assert property (p_change_seen) else $error("change bit lost");
    property p_read_clears;
        msr_rd && !loop && quiet && pins == p1 ##1 msr_rd && pins == p1 |=> reg_rdata[3:0] == 4'h0;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("change bits kept");
    property p_state_bits;
        msr_rd && !loop && pins == p1 && $stable(mcr_q) |=> reg_rdata[7:4] == ~p1;
    endproperty
    a_state_bits: assert property (p_state_bits) else $error("status bits wrong");
    property p_loop_bits;
        msr_rd && loop && $stable(mcr_q) |=> reg_rdata[7:4] == {mcr_q[3:2], mcr_q[0], mcr_q[1]};
    endproperty
    a_loop_bits: assert property (p_loop_bits) else $error("loop status wrong");
    property p_ring_fall;
        ier_q == 4'h8 && $stable(ier_q) && !loop && !irq && quiet && p2[2] && p1[2] && !pins[2]
            ##1 quiet && !pins[2] |=> !irq;
    endproperty
    a_ring_fall: assert property (p_ring_fall) else $error("ring fall flagged");
    property p_modem_irq;
        ier_q == 4'h8 && !loop && ((pins ^ p1) & 4'hb) != 4'h0 ##1 !(reg_rd || reg_wr) [*2] |-> ##[0:1] irq;
    endproperty
    a_modem_irq: assert property (p_modem_irq) else $error("no modem irq");
    property p_scratch;
        reg_rd && reg_addr == `USBF_ADDR_SCR |=> reg_rdata == scr_q;
    endproperty
    a_scratch: assert property (p_scratch) else $error("scratch wrong");
    property p_loop_pins;
        loop |-> serial_out && term_ready_n && req_send_n && aux_output_one_n && aux_output_two_n;
    endproperty
    a_loop_pins: assert property (p_loop_pins) else $error("loop pins active");
endmodule

// file: tb/usbf_modem.sv
/*
 * Modem model: drives the four active-low status pins and an idle receive line.
 * Assumes want is driven just after a clock edge; lag sets how slowly it answers.
 */
`timescale 1ns/1ps
module usbf_modem (
    input wire mclk,
    input wire [3:0] want,
    input wire [7:0] lag,
    output reg [3:0] pins_n,
    output wire line_out
);
    reg [7:0] cnt;
    reg [3:0] hold;

    // no frames are sent from this side, so the line rests at marking
    assign line_out = 1'b1;

    initial begin
        pins_n = 4'hf;
        cnt = 8'h00;
        hold = 4'h0;
    end

    always @(posedge mclk) begin
        if (want != hold) begin
            hold <= want;
            cnt <= lag;
        end else if (cnt != 8'h00)
            cnt <= cnt - 8'h01;
        else
            pins_n <= ~hold;
    end
endmodule

// file: tb/test_uart_modem_status_baud_fifo_irq.sv
/*
 * Testbench for the serial port block: register tasks, modem model, loopback traffic.
 * Assumes usbf_uart, usbf_map.vh, usbf_modem and the checker are compiled with it.
 */
`timescale 1ns/1ps
`include "usbf_map.vh"
module test_uart_modem_status_baud_fifo_irq;
    reg mclk, reset_n, reg_wr, reg_rd;
    reg [7:0] reg_addr, reg_wdata, lag;
    reg [3:0] want;
    wire [7:0] reg_rdata;
    wire [3:0] pins_n;
    wire serial_out, line_in, term_ready_n, req_send_n, aux_output_one_n, aux_output_two_n, irq;
    integer bad_count, n_compared, cyc, i, n;

    usbf_uart dut_u (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_in(line_in), .serial_out(serial_out),
        .carrier_detect_pin_n(pins_n[3]), .ring_pin_n(pins_n[2]), .set_ready_pin_n(pins_n[1]),
        .clear_to_send_pin_n(pins_n[0]), .term_ready_n(term_ready_n), .req_send_n(req_send_n),
        .aux_output_one_n(aux_output_one_n), .aux_output_two_n(aux_output_two_n), .irq(irq));
    usbf_modem modem_u (.mclk(mclk), .want(want), .lag(lag), .pins_n(pins_n), .line_out(line_in));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task end_sim;
        begin
            $display("compared %0d mismatched %0d", n_compared, bad_count);
            if (bad_count == 0 && n_compared > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask

    task chk(input string nm, input [7:0] e, input [7:0] g);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                bad_count = bad_count + 1;
                $display("MISMATCH %s expected %h seen %h", nm, e, g);
            end
        end
    endtask

    task tick(input integer k);
        begin
            repeat (k) @(posedge mclk);
            #1;
        end
    endtask

    task wr(input [7:0] a, input [7:0] v);
        begin
            reg_addr <= a;
            reg_wdata <= v;
            reg_wr <= 1'b1;
            @(posedge mclk);
            reg_wr <= 1'b0;
            #1;
        end
    endtask

    task rc(input [7:0] a, input [7:0] m, input [7:0] e, input string nm);
        begin
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge mclk);
            reg_rd <= 1'b0;
            #1;
            chk(nm, e, reg_rdata & m);
        end
    endtask

    // hang guard: the sequence needs about 9k cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            end_sim;
        end
    end

    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reset_n = 1'b0;
        want = 4'h0;
        lag = 8'h00;
        bad_count = 0;
        n_compared = 0;
        cyc = 0;
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        tick(1);
        rc(`USBF_ADDR_SCR, 8'hff, 8'h00, "scratch reset");
        rc(`USBF_ADDR_MSR, 8'hff, 8'h00, "status reset");
        wr(`USBF_ADDR_SCR, 8'ha5);
        rc(`USBF_ADDR_SCR, 8'hff, 8'ha5, "scratch");
        rc(8'h00, 8'hff, 8'h00, "unmapped");
        // ----------------------------------------
        // each modem input, from prompt to slow
        // ----------------------------------------
        wr(`USBF_ADDR_IER, 8'h08);
        for (i = 0; i < 4; i = i + 1) begin
            lag <= i[7:0] << 3;
            want <= 4'h1 << i;
            tick(i * 8 + 6);
            chk("irq on change", (i == 2) ? 8'h00 : 8'h01, {7'h00, irq});
            rc(`USBF_ADDR_MSR, 8'hff, {want, (i == 2) ? 4'h0 : want}, "status assert");
            rc(`USBF_ADDR_MSR, 8'h0f, 8'h00, "status cleared");
            want <= 4'h0;
            tick(i * 8 + 6);
            rc(`USBF_ADDR_MSR, 8'hff, 8'h01 << i, "status release");
            tick(2);
            chk("irq cleared", 8'h00, {7'h00, irq});
        end
        lag <= 8'h00;
        wr(`USBF_ADDR_MCR, 8'h1f);
        chk("loop pins", 8'h1f, {3'h0, serial_out, term_ready_n, req_send_n,
            aux_output_one_n, aux_output_two_n});
        tick(2);
        rc(`USBF_ADDR_MSR, 8'hf0, 8'hf0, "loop all");
        wr(`USBF_ADDR_MCR, 8'h15);
        want <= 4'hf;
        tick(4);
        rc(`USBF_ADDR_MSR, 8'hf0, 8'h60, "loop mix");
        want <= 4'h0;
        tick(4);
        wr(`USBF_ADDR_MCR, 8'h00);
        // one full data bit at divisor 3
        wr(`USBF_ADDR_DIV_LO, 8'h03);
        wr(`USBF_ADDR_DIV_HI, 8'h00);
        wr(`USBF_ADDR_DATA, 8'h55);
        for (i = 0; i < 3; i = i + 1) begin
            n = 0;
            while (serial_out !== i[0] && n < 200) begin
                tick(1);
                n = n + 1;
            end
        end
        chk("bit time", 8'h30, n[7:0]);
        tick(600);
        // transmit empty in FIFO mode
        wr(`USBF_ADDR_IER, 8'h02);
        wr(`USBF_ADDR_IIR_FCR, 8'h01);
        tick(2);
        chk("irq fifo on", 8'h01, {7'h00, irq});
        rc(`USBF_ADDR_IIR_FCR, 8'hff, 8'hc2, "ident tx");
        tick(2);
        chk("irq ident read", 8'h00, {7'h00, irq});
        wr(`USBF_ADDR_DATA, 8'ha5);
        tick(100);
        chk("lone byte early", 8'h00, {7'h00, irq});
        tick(600);
        chk("lone byte late", 8'h01, {7'h00, irq});
        rc(`USBF_ADDR_IIR_FCR, 8'h0f, 8'h02, "ident tx again");
        // receive through loopback, trigger level four
        wr(`USBF_ADDR_MCR, 8'h10);
        wr(`USBF_ADDR_IER, 8'h01);
        wr(`USBF_ADDR_IIR_FCR, 8'h41);
        wr(`USBF_ADDR_DATA, 8'h3c);
        tick(600);
        rc(`USBF_ADDR_LSR, 8'h01, 8'h01, "data ready");
        rc(`USBF_ADDR_IIR_FCR, 8'h0f, 8'h01, "below level");
        tick(2100);
        rc(`USBF_ADDR_IIR_FCR, 8'h0f, 8'h0c, "timeout");
        rc(`USBF_ADDR_DATA, 8'hff, 8'h3c, "rx byte");
        rc(`USBF_ADDR_IIR_FCR, 8'h0f, 8'h01, "timeout gone");
        rc(`USBF_ADDR_LSR, 8'h01, 8'h00, "fifo empty");
        for (i = 0; i < 4; i = i + 1)
            wr(`USBF_ADDR_DATA, 8'h10 + i[7:0]);
        tick(2200);
        rc(`USBF_ADDR_IIR_FCR, 8'h0f, 8'h04, "trigger");
        rc(`USBF_ADDR_DATA, 8'hff, 8'h10, "first out");
        rc(`USBF_ADDR_IIR_FCR, 8'h0f, 8'h01, "below again");
        // polled: no timeout shown, bytes kept
        wr(`USBF_ADDR_IER, 8'h00);
        tick(2100);
        rc(`USBF_ADDR_IIR_FCR, 8'h0f, 8'h01, "polled");
        rc(`USBF_ADDR_LSR, 8'h01, 8'h01, "polled ready");
        for (i = 1; i < 4; i = i + 1)
            rc(`USBF_ADDR_DATA, 8'hff, 8'h10 + i[7:0], "kept");
        end_sim;
    end
endmodule

bind usbf_uart usbf_chk chk_u (.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .serial_out, .carrier_detect_pin_n, .ring_pin_n, .set_ready_pin_n, .clear_to_send_pin_n,
    .term_ready_n, .req_send_n, .aux_output_one_n, .aux_output_two_n, .irq);
